// ===== design/vbc_regs.sv
// Function
// RULE1 - single mode: select bit picks input
// RULE2 - independent mode: select bit swaps output routing
// RULE3 - software keeps select zero in dual
// RULE4 - stereo bit merges interleaved lines
// RULE5 - software sets forced splitter for separation
// RULE6 - lane field gives active lanes
// RULE7 - lane field loads from strap pin
// RULE8 - software changes lanes only when idle
// RULE9 - independent mode writes only selected copy; dual_en, port_sel, alt_lines written to both copies
// RULE10 - reload bit restores straps, self clears
// RULE11 - config done precedes init done
// RULE12 - checksum status bit, resets one
// RULE13 - read-only protect interrupt pending bit
// RULE14 - bytes per pixel field decode
// RULE15 - RGB expands to 24 bits, others pass
// RULE16 - mux audio serialises parallel data
// RULE17 - audio source select, resets one
// RULE18 - aux audio adds 2-channel stream
// RULE19 - dual enable picks receive mode
// RULE20 - free-running clock skips clock init
// RULE21 - reserved bits read zero
`timescale 1ns/1ps
`default_nettype none
module vbc_regs (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [9:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [9:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [1:0]             mode_select_zero_pin,
    input  wire logic                   mode_select_one_pin,
    input  wire logic                   independent_mode,
    input  wire logic                   tx_port_sel,
    input  wire logic                   nvm_checksum_ok,
    input  wire logic                   content_protect_irq_pending,
    input  wire logic                   rgb_format,
    output vbc_pkg::vbc_ctrl_out_t      ctrl_out,
    output logic                        nvm_reload_req
);
    // ****************
    // register state
    // ****************
    vbc_pkg::vbc_port_cfg_t port_reg [2];
    vbc_pkg::vbc_port_cfg_t port_next [2];
    logic [1:0]             bpp_reg [2];
    logic [1:0]             bpp_next [2];
    logic [2:0]             audio_reg;
    logic [2:0]             audio_next;
    logic                   reload_reg;
    logic                   reload_next;
    logic                   cfg_done_reg;
    logic                   cfg_done_next;
    logic                   init_done_reg;
    logic                   init_done_next;
    logic                   cksum_reg;
    logic                   cksum_next;
    logic                   strap_take_reg;
    vbc_pkg::vbc_seq_t      seq_reg;
    vbc_pkg::vbc_seq_t      seq_next;
    logic [vbc_pkg::CNT_W-1:0] cnt_reg;
    logic [vbc_pkg::CNT_W-1:0] cnt_next;
    logic                   aw_hold_reg;
    logic [9:0]             aw_addr_reg;
    logic                   w_hold_reg;
    logic [31:0]            w_data_reg;
    logic [3:0]             w_strb_reg;
    logic                   bvalid_reg;
    logic [1:0]             bresp_reg;
    logic                   rvalid_reg;
    logic [31:0]            rdata_reg;
    logic [1:0]             rresp_reg;

    // ****************
    // axi4-lite write and read decode
    // ****************
    wire        do_write   = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire        wr_lane0   = w_strb_reg[0];
    wire [7:0]  wr_byte    = w_data_reg[7:0];
    wire        wr_ctl     = do_write && aw_addr_reg == vbc_pkg::CTL_ADDR;
    wire        wr_cfg     = do_write && aw_addr_reg == vbc_pkg::CFG_ADDR;
    wire        wr_sts     = do_write && aw_addr_reg == vbc_pkg::STS_ADDR;
    wire        wr_mode    = do_write && aw_addr_reg == vbc_pkg::MODE_ADDR;
    wire        wr_ok      = wr_ctl || wr_cfg || wr_sts || wr_mode;
    wire        do_read    = s_axi_arvalid && !rvalid_reg;
    // independent mode targets the selected output port's copy [RULE9]
    wire        sel_port   = independent_mode ? tx_port_sel : 1'b0;
    wire        reload_go  = wr_ctl && wr_lane0 && wr_byte[vbc_pkg::CTL_RELOAD];
    wire        restrap    = strap_take_reg || (seq_reg == vbc_pkg::VBC_CFG &&
                                                cnt_reg == '0);
    wire [7:0]  ctl_rd     = {port_reg[sel_port].cont_clk, port_reg[0].dual_en,
                              port_reg[0].port_sel, port_reg[0].alt_lines,
                              port_reg[sel_port].lanes, reload_reg, 1'b0};
    // reserved bits read zero [RULE21]
    wire [7:0]  sts_rd     = {2'b00, content_protect_irq_pending, init_done_reg, 1'b0,
                              cfg_done_reg, cksum_reg, 1'b0}; // [RULE13] [RULE12]
    wire [7:0]  cfg_rd     = {2'b00, bpp_reg[sel_port], 1'b0, audio_reg};
    wire [7:0]  mode_rd    = {7'b000_0000, independent_mode};
    wire [9:0]  rd_a       = s_axi_araddr;
    wire        rd_hit     = rd_a == vbc_pkg::CTL_ADDR || rd_a == vbc_pkg::STS_ADDR ||
                             rd_a == vbc_pkg::CFG_ADDR || rd_a == vbc_pkg::MODE_ADDR;
    wire [7:0]  rd_byte    = rd_a == vbc_pkg::CTL_ADDR ? ctl_rd :
                             rd_a == vbc_pkg::STS_ADDR ? sts_rd :
                             rd_a == vbc_pkg::CFG_ADDR ? cfg_rd :
                             rd_a == vbc_pkg::MODE_ADDR ? mode_rd : 8'h00;

    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready  = !w_hold_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // ****************
    // per-port control copies
    // ****************
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_port
            wire hit = wr_ctl && wr_lane0 && (sel_port == 1'(gp));
            wire hit_cfg = wr_cfg && wr_lane0 && (sel_port == 1'(gp));
            always_comb begin
                port_next[gp] = port_reg[gp];
                bpp_next[gp]  = bpp_reg[gp];
                if (restrap) begin
                    // straps come back [RULE7] [RULE10]
                    port_next[gp].lanes    = mode_select_zero_pin;
                    port_next[gp].cont_clk = mode_select_one_pin;
                end else begin
                    if (hit) begin
                        port_next[gp].lanes    = wr_byte[vbc_pkg::CTL_LANES_LO +: 2]; // [RULE9]
                        port_next[gp].cont_clk = wr_byte[vbc_pkg::CTL_CONT_CLK];
                    end
                    if (wr_ctl && wr_lane0) begin
                        port_next[gp].dual_en   = wr_byte[vbc_pkg::CTL_DUAL_EN];
                        port_next[gp].port_sel  = wr_byte[vbc_pkg::CTL_PORT_SEL];
                        port_next[gp].alt_lines = wr_byte[vbc_pkg::CTL_ALT_LINES];
                    end
                    if (hit_cfg) begin
                        bpp_next[gp] = wr_byte[vbc_pkg::CFG_BPP_LO +: 2];
                    end
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    port_reg[gp] <= '0;
                    bpp_reg[gp]  <= vbc_pkg::VBC_BPP_3;
                end else begin
                    port_reg[gp] <= port_next[gp];
                    bpp_reg[gp]  <= bpp_next[gp];
                end
            end
        end
    endgenerate

    // ****************
    // reload sequencer
    // ****************
    always_comb begin
        seq_next       = seq_reg;
        cnt_next       = cnt_reg;
        reload_next    = reload_reg;
        cfg_done_next  = cfg_done_reg;
        init_done_next = init_done_reg;
        cksum_next     = cksum_reg;
        audio_next     = audio_reg;
        if (wr_cfg && wr_lane0) begin
            audio_next = wr_byte[2:0];
        end
        unique case (seq_reg)
            vbc_pkg::VBC_IDLE: begin
                if (reload_go) begin
                    // restart: config done drops until the config phase ends, init done until the new pass ends [RULE10]
                    seq_next       = vbc_pkg::VBC_CFG;
                    cnt_next       = vbc_pkg::CNT_W'(vbc_pkg::CFG_CYCLES - 1);
                    reload_next    = 1'b1;
                    cfg_done_next  = 1'b0;
                    init_done_next = 1'b0;
                end
            end
            vbc_pkg::VBC_CFG: begin
                if (cnt_reg == '0) begin
                    seq_next      = vbc_pkg::VBC_INIT;
                    cnt_next      = vbc_pkg::CNT_W'(vbc_pkg::INIT_CYCLES - 1);
                    cfg_done_next = 1'b1; // [RULE11]
                    audio_next    = vbc_pkg::CFG_RESET[2:0];
                    cksum_next    = nvm_checksum_ok; // [RULE12]
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            vbc_pkg::VBC_INIT: begin
                if (cnt_reg == '0) begin
                    seq_next       = vbc_pkg::VBC_IDLE;
                    init_done_next = 1'b1; // [RULE11]
                    reload_next    = 1'b0; // [RULE10]
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                seq_next = vbc_pkg::VBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_reg        <= vbc_pkg::VBC_IDLE;
            cnt_reg        <= '0;
            reload_reg     <= 1'b0;
            cfg_done_reg   <= 1'b0;
            init_done_reg  <= 1'b0;
            cksum_reg      <= 1'b1;
            audio_reg      <= vbc_pkg::CFG_RESET[2:0]; // [RULE17]
            strap_take_reg <= 1'b1;
        end else begin
            seq_reg        <= seq_next;
            cnt_reg        <= cnt_next;
            reload_reg     <= reload_next;
            cfg_done_reg   <= cfg_done_next;
            init_done_reg  <= init_done_next;
            cksum_reg      <= cksum_next;
            audio_reg      <= audio_next;
            strap_take_reg <= 1'b0;
        end
    end

    // ****************
    // bus channel state
    // ****************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= vbc_pkg::RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= vbc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_hold_reg) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[9:2], 2'b00};
            end
            if (s_axi_wvalid && !w_hold_reg) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_ok ? vbc_pkg::RESP_OKAY : vbc_pkg::RESP_SLVERR;
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (do_read) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= {24'h00_0000, rd_byte};
                rresp_reg  <= rd_hit ? vbc_pkg::RESP_OKAY : vbc_pkg::RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ****************
    // control outputs to the datapath
    // ****************
    wire       dual_on  = port_reg[0].dual_en; // [RULE19]
    wire       psel     = port_reg[0].port_sel;
    wire [1:0] p0_src   = independent_mode ? {1'b0, psel} :          // [RULE2]
                          dual_on ? 2'b10 : {1'b0, psel};             // [RULE1]
    wire [1:0] p1_src   = independent_mode ? {1'b0, !psel} : p0_src; // [RULE2]
    wire [1:0] bpp_sel  = bpp_reg[sel_port];
    wire       cont_clk = port_reg[sel_port].cont_clk;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_out       <= '0;
            nvm_reload_req <= 1'b0;
        end else begin
            ctrl_out.port0_src     <= p0_src;
            ctrl_out.port1_src     <= p1_src;
            ctrl_out.lanes_active  <= {1'b0, port_reg[sel_port].lanes} + 3'd1; // [RULE6]
            ctrl_out.skip_clk_init <= cont_clk;                                 // [RULE20]
            ctrl_out.stereo_merge  <= port_reg[0].alt_lines;                    // [RULE4]
            ctrl_out.rgb_expand    <= rgb_format;                               // [RULE15]
            ctrl_out.bpp           <= cont_clk ? bpp_sel : vbc_pkg::VBC_BPP_3;  // [RULE14]
            ctrl_out.audio_on      <= audio_reg[vbc_pkg::CFG_AUDIO_SRC];        // [RULE17]
            ctrl_out.audio_mux     <= audio_reg[vbc_pkg::CFG_AUDIO_MUX];        // [RULE16]
            ctrl_out.aux_audio     <= audio_reg[vbc_pkg::CFG_AUX_AUDIO];        // [RULE18]
            nvm_reload_req         <= seq_next == vbc_pkg::VBC_CFG;
        end
    end
endmodule
`default_nettype wire

// ===== common/vbc_pkg.sv
`default_nettype none
package vbc_pkg;
    // register indices
    localparam logic [7:0] CTL_OFFSET    = 8'h4F;
    localparam logic [7:0] STS_OFFSET    = 8'h50;
    localparam logic [7:0] CFG_OFFSET    = 8'h54;
    localparam logic [7:0] MODE_OFFSET   = 8'h58;
    // byte address is four times the index
    localparam logic [9:0] CTL_ADDR      = {CTL_OFFSET, 2'b00};
    localparam logic [9:0] STS_ADDR      = {STS_OFFSET, 2'b00};
    localparam logic [9:0] CFG_ADDR      = {CFG_OFFSET, 2'b00};
    localparam logic [9:0] MODE_ADDR     = {MODE_OFFSET, 2'b00};
    // control field positions
    localparam int CTL_CONT_CLK    = 7;
    localparam int CTL_DUAL_EN     = 6;
    localparam int CTL_PORT_SEL    = 5;
    localparam int CTL_ALT_LINES   = 4;
    localparam int CTL_LANES_LO    = 2;
    localparam int CTL_RELOAD      = 1;
    // status field positions
    localparam int STS_IRQ_PEND    = 5;
    localparam int STS_INIT_DONE   = 4;
    localparam int STS_CFG_DONE    = 2;
    localparam int STS_CKSUM_OK    = 1;
    // config field positions
    localparam int CFG_BPP_LO      = 4;
    localparam int CFG_AUDIO_MUX   = 2;
    localparam int CFG_AUDIO_SRC   = 1;
    localparam int CFG_AUX_AUDIO   = 0;
    localparam logic [7:0] CFG_RESET = 8'h02;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // reload sequencing times
    localparam int CLK_MHZ         = 25;
    localparam int CFG_TIME_NS     = 400;
    localparam int INIT_TIME_NS    = 200;
    localparam int CFG_CYCLES      = (CFG_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_CYCLES     = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W           = 8;
    typedef enum logic [1:0] {
        VBC_IDLE = 2'b00,
        VBC_CFG  = 2'b01,
        VBC_INIT = 2'b11
    } vbc_seq_t;
    typedef enum logic [1:0] {
        VBC_BPP_3    = 2'b00,
        VBC_BPP_2_25 = 2'b01,
        VBC_BPP_2    = 2'b10,
        VBC_BPP_RSVD = 2'b11
    } vbc_bpp_t;
    typedef struct packed {
        logic       cont_clk;
        logic       dual_en;
        logic       port_sel;
        logic       alt_lines;
        logic [1:0] lanes;
    } vbc_port_cfg_t;
    typedef struct packed {
        logic [1:0] port0_src;
        logic [1:0] port1_src;
        logic [2:0] lanes_active;
        logic       skip_clk_init;
        logic       stereo_merge;
        logic       rgb_expand;
        logic [1:0] bpp;
        logic       audio_on;
        logic       audio_mux;
        logic       aux_audio;
    } vbc_ctrl_out_t;
endpackage
`default_nettype wire

// ===== sim/vbc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port-level checks of the register bank
// ****************************************
module vbc_regs_sva (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic [9:0]             s_axi_araddr,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic                   s_axi_rvalid,
    input wire logic                   independent_mode,
    input wire logic                   content_protect_irq_pending,
    input wire logic                   rgb_format,
    input wire logic [1:0]             mode_select_zero_pin,
    input wire vbc_pkg::vbc_ctrl_out_t ctrl_out,
    input wire logic                   nvm_reload_req
);
    logic rd_sts_reg;
    // read in flight targets status
    always_ff @(posedge aclk) begin
        if (!aresetn) rd_sts_reg <= 1'b0;
        else if (s_axi_arvalid && s_axi_arready) rd_sts_reg <= (s_axi_araddr == vbc_pkg::STS_ADDR);
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_reload_start; $rose(nvm_reload_req); endsequence
    sequence s_cfg_phase; nvm_reload_req [*8]; endsequence
    property p_reload_hold; s_reload_start |-> s_cfg_phase; endproperty
    a_reload_hold: assert property (p_reload_hold) else $error("reload too short");
    property p_reload_end; s_reload_start |-> ##[9:12] !nvm_reload_req; endproperty
    a_reload_end: assert property (p_reload_end) else $error("reload too long");
    property p_bpp; !ctrl_out.skip_clk_init |-> ctrl_out.bpp == 2'b00; endproperty
    a_bpp: assert property (p_bpp) else $error("bpp not forced");
    property p_lanes; $rose(aresetn) |-> ##2 ctrl_out.lanes_active == {1'b0, mode_select_zero_pin} + 3'd1; endproperty
    a_lanes: assert property (p_lanes) else $error("lanes not strapped");
    property p_rgb; $past(aresetn) |-> ctrl_out.rgb_expand == $past(rgb_format); endproperty
    a_rgb: assert property (p_rgb) else $error("rgb not mirrored");
    property p_swap;
        $past(independent_mode) && $past(aresetn) |-> !ctrl_out.port0_src[1]
            && ctrl_out.port1_src == {1'b0, ~ctrl_out.port0_src[0]};
    endproperty
    a_swap: assert property (p_swap) else $error("routing not swapped");
    property p_cfg_first; s_axi_rvalid && rd_sts_reg && s_axi_rdata[4] |-> s_axi_rdata[2]; endproperty
    a_cfg_first: assert property (p_cfg_first) else $error("init done before config done");
    property p_irq;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == vbc_pkg::STS_ADDR
            |=> s_axi_rdata[5] == $past(content_protect_irq_pending);
    endproperty
    a_irq: assert property (p_irq) else $error("pending bit wrong");
    property p_rsvd;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000
            && (!rd_sts_reg || (s_axi_rdata[7:6] == 2'b00 && !s_axi_rdata[3] && !s_axi_rdata[0]));
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_audio_rst; $rose(aresetn) |=> ctrl_out.audio_on; endproperty
    a_audio_rst: assert property (p_audio_rst) else $error("audio off after reset");
endmodule
bind vbc_regs vbc_regs_sva u_sva (
    .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .independent_mode, .content_protect_irq_pending, .rgb_format, .ctrl_out, .nvm_reload_req,
    .mode_select_zero_pin
);
`default_nettype wire

// ===== sim/vbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host software access over the register bus
// ****************************************
module vbc_host_model (
    input  wire logic        aclk,
    output logic [9:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [9:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr} = 20'h0_0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h0;
    end
    // only byte lane 0 carries register data
    task automatic write(input logic [9:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask
    task automatic read(input logic [9:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// register bank test sequence
// ****************************************
module tb;
    logic                   aclk = 1'b0;
    logic                   aresetn = 1'b0;
    logic [9:0]             s_axi_awaddr, s_axi_araddr;
    logic [31:0]            s_axi_wdata, s_axi_rdata, d;
    logic [3:0]             s_axi_wstrb;
    logic [1:0]             s_axi_bresp, s_axi_rresp, r;
    logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, nvm_reload_req;
    logic [1:0]             mode_select_zero_pin = 2'b10;
    logic                   mode_select_one_pin = 1'b1;
    logic                   independent_mode = 1'b0;
    logic                   tx_port_sel = 1'b0;
    logic                   nvm_checksum_ok = 1'b1;
    logic                   content_protect_irq_pending = 1'b0;
    logic                   rgb_format = 1'b1;
    vbc_pkg::vbc_ctrl_out_t ctrl_out;
    int                     bad_count = 0;
    int                     n_tests = 0;
    int                     cycles = 0;
    always #20 aclk = ~aclk;
    vbc_host_model u_host (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    vbc_regs dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .mode_select_zero_pin, .mode_select_one_pin, .independent_mode, .tx_port_sel, .nvm_checksum_ok,
        .content_protect_irq_pending, .rgb_format, .ctrl_out, .nvm_reload_req
    );
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
        chk(nm, {30'h0, exp}, {30'h0, got});
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp, input logic [7:0] m);
        u_host.read(a, d, r);
        chk_resp("rresp", vbc_pkg::RESP_OKAY, r);
        chk("rdata", {24'h00_0000, exp & m}, d & {24'hFF_FFFF, m});
    endtask
    // let registered outputs settle
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        u_host.write(a, {24'h00_0000, v}, r);
        chk_resp("bresp", vbc_pkg::RESP_OKAY, r);
        repeat (2) @(posedge aclk);
    endtask
    task automatic conclude;
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(vbc_pkg::CTL_ADDR, 8'h88, 8'hFF);
        rd(vbc_pkg::STS_ADDR, 8'h02, 8'hFF);
        rd(vbc_pkg::CFG_ADDR, 8'h02, 8'hFF);
        chk("lanes", 3'd3, ctrl_out.lanes_active);
        wr(vbc_pkg::CTL_ADDR, 8'hB5);
        rd(vbc_pkg::CTL_ADDR, 8'hB4, 8'hFF);
        chk("lanes", 3'd2, ctrl_out.lanes_active);
        chk("stereo", 1'b1, ctrl_out.stereo_merge);
        chk("skip", 1'b1, ctrl_out.skip_clk_init);
        chk("src0", 2'd1, ctrl_out.port0_src);
        wr(vbc_pkg::CTL_ADDR, 8'h44);
        chk("src0", 2'd2, ctrl_out.port0_src);
        wr(vbc_pkg::CTL_ADDR, 8'h84);
        for (int i = 0; i < 4; i++) begin
            wr(vbc_pkg::CFG_ADDR, {2'b00, i[1:0], 4'h5});
            rd(vbc_pkg::CFG_ADDR, {2'b00, i[1:0], 4'h5}, 8'hFF);
            chk("bpp", i[1:0], ctrl_out.bpp);
            chk("mux", 1'b1, ctrl_out.audio_mux);
            chk("aux", 1'b1, ctrl_out.aux_audio);
            chk("audio", 1'b0, ctrl_out.audio_on);
        end
        wr(vbc_pkg::CTL_ADDR, 8'h04);
        chk("bpp", 2'd0, ctrl_out.bpp);
        chk("skip", 1'b0, ctrl_out.skip_clk_init);
        wr(vbc_pkg::CFG_ADDR, 8'hFF);
        rd(vbc_pkg::CFG_ADDR, 8'h37, 8'hFF);
        wr(vbc_pkg::STS_ADDR, 8'hFF);
        content_protect_irq_pending <= 1'b1;
        rd(vbc_pkg::STS_ADDR, 8'h22, 8'hFF);
        content_protect_irq_pending <= 1'b0;
        u_host.read(10'h004, d, r);
        chk_resp("rresp", vbc_pkg::RESP_SLVERR, r);
        chk("rdata", 32'h0000_0000, d);
        independent_mode <= 1'b1;
        wr(vbc_pkg::CTL_ADDR, 8'h00);
        rd(vbc_pkg::MODE_ADDR, 8'h01, 8'hFF);
        tx_port_sel <= 1'b1;
        wr(vbc_pkg::CTL_ADDR, 8'h2C);
        rd(vbc_pkg::CTL_ADDR, 8'h2C, 8'hFF);
        chk("src0", 2'd1, ctrl_out.port0_src);
        chk("src1", 2'd0, ctrl_out.port1_src);
        tx_port_sel <= 1'b0;
        rd(vbc_pkg::CTL_ADDR, 8'h20, 8'hFF);
        chk("lanes", 3'd1, ctrl_out.lanes_active);
        independent_mode <= 1'b0;
        nvm_checksum_ok <= 1'b0;
        wr(vbc_pkg::CTL_ADDR, 8'h02);
        for (int i = 0; i < 20; i++) begin
            u_host.read(vbc_pkg::CTL_ADDR, d, r);
            if (d[1] === 1'b0) break;
        end
        rd(vbc_pkg::CTL_ADDR, 8'h88, 8'h8E);
        rd(vbc_pkg::STS_ADDR, 8'h14, 8'hFF);
        rd(vbc_pkg::CFG_ADDR, 8'h02, 8'h07);
        rgb_format <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("rgb", 1'b0, ctrl_out.rgb_expand);
        conclude();
    end
endmodule
`default_nettype wire
